// *** ais_defs.svh ***
`ifndef AIS_DEFS_SVH
`define AIS_DEFS_SVH
`define AIS_AW 12
`define AIS_OFF_CH123 12'h000
`define AIS_OFF_CH0 12'h004
`define AIS_OFF_SCANH 12'h008
`define AIS_OFF_SCANL 12'h00C
`define AIS_OFF_PCFGH 12'h010
`define AIS_OFF_PCFGL 12'h014
`define AIS_RST16 16'h0000
`define AIS_WM_CH123 16'h0707
`define AIS_WM_CH0 16'h9F9F
`define AIS_WM_CH0_LOW 16'h8F8F
`define AIS_C123_SA 0
`define AIS_C123_NA_HI 2
`define AIS_C123_NA_LO 1
`define AIS_C123_SB 8
`define AIS_C123_NB_HI 10
`define AIS_C123_NB_LO 9
`define AIS_C0_SA_HI 4
`define AIS_C0_NA 7
`define AIS_C0_SB_HI 12
`define AIS_C0_SB_LO 8
`define AIS_C0_NB 15
`define AIS_NEG_HI_BASE 5'h09
`define AIS_NEG_LO_BASE 5'h06
`define AIS_POS_HI_BASE 5'h03
`define AIS_NEG_C0_PIN 5'h01
`endif

// *** ais_pkg.sv ***
`default_nettype none
package ais_pkg;
	typedef struct packed {
		logic                psel;
		logic                penable;
		logic                pwrite;
		logic [11:0]         paddr;
		logic [31:0]         pwdata;
	} ais_apb_req_type;
	typedef struct packed {
		logic [4:0] pos_pin;
		logic       pos_vref;
		logic [4:0] neg_pin;
		logic       neg_vref;
	} ais_route_type;
	typedef enum logic [1:0] {
		AIS_SET_A = 2'b01,
		AIS_SET_B = 2'b10
	} ais_set_type;
endpackage : ais_pkg
`default_nettype wire

// *** ais_input_select.sv ***
// Function
// - set B ch1-3 negative: 9-11, 6-8, reference
// - set A ch1-3 negative: same encoding
// - set B ch1-3 positive: 3-5 or 0-2
// - set A ch1-3 positive: 3-5 or 0-2
// - twelve-bit mode: ch1-3 fields read zero
// - ch0 negative: pin 1 or reference
// - set A ch0 positive: pin equals code
// - set B ch0 positive decodes like A
// - second converter: ch0 positive pins 0-15
// - scan bit n includes pin n
// - scanning absent pin converts positive reference
// - config one: digital, read on, ground
// - config zero: analog, pin sampled
// - absent pin config bits stored, no effect
// - module disabled: all pins digital
// - second converter: no high config register
// - scan only when scan enable set
// - alternate mode: A then B samples
//
// Design decisions made here: the APB slave port and the address map.
`include "ais_defs.svh"
`default_nettype none
module ais_input_select
	import ais_pkg::*;
#(
	parameter int NUM_PINS    = 32,
	parameter bit SECOND_CONV = 1'b0,
	parameter bit HAS_PEER    = 1'b0
) (
	// clock and reset
	input  wire logic            clk,
	input  wire logic            rst_b,
	// apb slave
	input  wire ais_apb_req_type apb_req,
	output var  logic [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	// converter control
	input  wire logic            twelve_bit_mode,
	input  wire logic            converter_module_disable,
	input  wire logic            scan_enable,
	input  wire logic            alternate_sample_mode,
	input  wire logic            sample_done,
	input  wire logic [15:0]     peer_pin_digital_mode_bit_low,
	// routing
	output var  ais_route_type   route_q [4],
	output var  ais_set_type     set_q,
	output var  logic [4:0]      scan_idx_q,
	output var  logic [31:0]     pin_digital_q
);
	localparam logic [31:0] PIN_MASK =
		(NUM_PINS == 32) ? 32'hFFFF_FFFF :
		((32'h0000_0001 << NUM_PINS) - 32'h0000_0001);

	if (NUM_PINS < 1 || NUM_PINS > 32) begin : g_bad_pins
		$error("NUM_PINS out of range");
	end
	if (SECOND_CONV && NUM_PINS > 16) begin : g_bad_second
		$error("second converter has 16 pins");
	end

	logic [15:0] ch123_q;
	logic [15:0] ch0_q;
	logic [15:0] scanh_q;
	logic [15:0] scanl_q;
	logic [15:0] pcfgh_q;
	logic [15:0] pcfgl_q;
	logic [31:0] prdata_q;
	logic        setup;
	logic        access;
	logic        hit;
	logic [15:0] rd_d;
	logic [15:0] wdat;
	logic [15:0] ch0_wm;

	assign setup  = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable;
	assign wdat   = apb_req.pwdata[15:0];
	assign pready = 1'b1;
	assign ch0_wm = SECOND_CONV ? `AIS_WM_CH0_LOW : `AIS_WM_CH0;

	always_comb begin
		hit  = 1'b1;
		rd_d = `AIS_RST16;
		case (apb_req.paddr)
			`AIS_OFF_CH123: rd_d = twelve_bit_mode ? `AIS_RST16 : ch123_q;
			`AIS_OFF_CH0:   rd_d = ch0_q;
			`AIS_OFF_SCANH: rd_d = scanh_q;
			`AIS_OFF_SCANL: rd_d = scanl_q;
			`AIS_OFF_PCFGH: begin
				hit  = !SECOND_CONV;
				rd_d = SECOND_CONV ? `AIS_RST16 : pcfgh_q;
			end
			`AIS_OFF_PCFGL: rd_d = pcfgl_q;
			default:        hit = 1'b0;
		endcase
	end

	assign pslverr = access && !hit;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= {16'h0000, rd_d};
		end
	end
	assign prdata = prdata_q;

	logic wr;
	assign wr = access && apb_req.pwrite;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ch123_q <= `AIS_RST16;
			ch0_q   <= `AIS_RST16;
		end else if (wr) begin
			if (apb_req.paddr == `AIS_OFF_CH123 && !twelve_bit_mode)
				ch123_q <= wdat & `AIS_WM_CH123;
			if (apb_req.paddr == `AIS_OFF_CH0)
				ch0_q <= wdat & ch0_wm;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scanh_q <= `AIS_RST16;
			scanl_q <= `AIS_RST16;
		end else if (wr) begin
			if (apb_req.paddr == `AIS_OFF_SCANH)
				scanh_q <= wdat;
			if (apb_req.paddr == `AIS_OFF_SCANL)
				scanl_q <= wdat;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pcfgh_q <= `AIS_RST16;
			pcfgl_q <= `AIS_RST16;
		end else if (wr) begin
			if (apb_req.paddr == `AIS_OFF_PCFGH && !SECOND_CONV)
				pcfgh_q <= wdat;
			if (apb_req.paddr == `AIS_OFF_PCFGL)
				pcfgl_q <= wdat;
		end
	end

	// alternate sample sequencing
	// toggle A and B
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			set_q <= AIS_SET_A;
		end else if (!alternate_sample_mode) begin
			set_q <= AIS_SET_A;
		end else if (sample_done) begin
			case (set_q)
				AIS_SET_A: set_q <= AIS_SET_B;
				AIS_SET_B: set_q <= AIS_SET_A;
				default:   set_q <= AIS_SET_A;
			endcase
		end
	end

	// scan pointer
	logic [31:0] scan_mask;
	assign scan_mask = {scanh_q, scanl_q};

	function automatic logic [4:0] next_scan(
		input logic [31:0] mask,
		input logic [4:0]  idx
	);
		logic [4:0] cand;
		logic       found;
		next_scan = idx;
		found     = 1'b0;
		for (int i = 1; i <= 32; i++) begin
			cand = idx + i[4:0];
			if (!found && mask[cand]) begin
				next_scan = cand;
				found     = 1'b1;
			end
		end
	endfunction : next_scan

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scan_idx_q <= 5'h00;
		end else if (scan_enable && sample_done && set_q == AIS_SET_A) begin
			scan_idx_q <= next_scan(scan_mask, scan_idx_q);
		end
	end

	// input routing decode
	logic          use_b;
	logic [1:0]    ch123_n;
	logic          ch123_p;
	logic [4:0]    ch0_p;
	logic          ch0_n;
	ais_route_type route_d [4];

	assign use_b   = (set_q == AIS_SET_B);
	assign ch123_n = use_b ?
		ch123_q[`AIS_C123_NB_HI:`AIS_C123_NB_LO] :
		ch123_q[`AIS_C123_NA_HI:`AIS_C123_NA_LO];
	assign ch123_p = use_b ? ch123_q[`AIS_C123_SB] : ch123_q[`AIS_C123_SA];
	assign ch0_p = use_b ? ch0_q[`AIS_C0_SB_HI:`AIS_C0_SB_LO] :
		ch0_q[`AIS_C0_SA_HI:0];
	assign ch0_n = use_b ? ch0_q[`AIS_C0_NB] : ch0_q[`AIS_C0_NA];

	always_comb begin
		if (scan_enable && !use_b) begin
			route_d[0].pos_pin  = scan_idx_q;
			route_d[0].pos_vref = (32'(scan_idx_q) >= NUM_PINS);
		end else begin
			route_d[0].pos_pin  = ch0_p;
			route_d[0].pos_vref = 1'b0;
		end
		route_d[0].neg_pin  = ch0_n ? `AIS_NEG_C0_PIN : 5'h00;
		route_d[0].neg_vref = !ch0_n;
	end

	genvar k;
	generate
		for (k = 1; k < 4; k++) begin : g_ch
			localparam logic [4:0] OFS = 5'(k - 1);
			always_comb begin
				route_d[k].pos_vref = 1'b0;
				route_d[k].pos_pin  = OFS;
				route_d[k].neg_vref = 1'b1;
				route_d[k].neg_pin  = 5'h00;
				if (!twelve_bit_mode) begin
					route_d[k].pos_pin = ch123_p ?
						(`AIS_POS_HI_BASE + OFS) : OFS;
					if (ch123_n[1]) begin
						route_d[k].neg_vref = 1'b0;
						route_d[k].neg_pin  = ch123_n[0] ?
							(`AIS_NEG_HI_BASE + OFS) :
							(`AIS_NEG_LO_BASE + OFS);
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int c = 0; c < 4; c++)
				route_q[c] <= '0;
		end else begin
			for (int c = 0; c < 4; c++)
				route_q[c] <= route_d[c];
		end
	end

	// pin analog or digital mode
	logic [31:0] pin_digital_mode_bit_eff;
	always_comb begin
		pin_digital_mode_bit_eff = {pcfgh_q, pcfgl_q};
		if (SECOND_CONV)
			pin_digital_mode_bit_eff[31:16] = 16'h0000;
		if (HAS_PEER)
			pin_digital_mode_bit_eff[15:0] = pcfgl_q & peer_pin_digital_mode_bit_low;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_digital_q <= 32'h0000_0000;
		end else if (converter_module_disable) begin
			pin_digital_q <= PIN_MASK;
		end else begin
			pin_digital_q <= pin_digital_mode_bit_eff & PIN_MASK;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_disable_digital: assert property (
		converter_module_disable |=> pin_digital_q == PIN_MASK)
		else $error("disabled converter left pin analog");

	a_twelve_read_zero: assert property (
		setup && apb_req.paddr == `AIS_OFF_CH123 && twelve_bit_mode
		|=> prdata == 32'h0000_0000)
		else $error("ch1-3 select visible in twelve-bit mode");

	a_alt_to_b: assert property (
		alternate_sample_mode && sample_done && set_q == AIS_SET_A
		|=> set_q == AIS_SET_B)
		else $error("alternate mode did not move to set B");

	a_set_a_only: assert property (
		!alternate_sample_mode |=> set_q == AIS_SET_A)
		else $error("set B used without alternate mode");

	a_ch0_pos_code: assert property (
		set_q == AIS_SET_A && !scan_enable
		|=> route_q[0].pos_pin == $past(ch0_q[`AIS_C0_SA_HI:0]))
		else $error("ch0 positive pin differs from code");

	a_ch123_neg_hi: assert property (
		!twelve_bit_mode && set_q == AIS_SET_A &&
		ch123_q[`AIS_C123_NA_HI:`AIS_C123_NA_LO] == 2'b11
		|=> route_q[1].neg_pin == `AIS_NEG_HI_BASE && !route_q[3].neg_vref &&
		route_q[3].neg_pin == 5'h0B)
		else $error("ch1-3 negative high trio wrong");

	a_scan_absent_ref: assert property (
		scan_enable && set_q == AIS_SET_A && 32'(scan_idx_q) >= NUM_PINS
		|=> route_q[0].pos_vref)
		else $error("absent scanned pin not on reference");

	a_unmapped_err: assert property (
		access && apb_req.paddr == `AIS_OFF_PCFGH && SECOND_CONV |-> pslverr)
		else $error("missing high config register answered");

	a_ch0_neg_ref: assert property (
		set_q == AIS_SET_A && !ch0_q[`AIS_C0_NA]
		|=> route_q[0].neg_vref && route_q[0].neg_pin == 5'h00)
		else $error("ch0 negative not on reference");

	a_ch123_neg_ref: assert property (
		!twelve_bit_mode && set_q == AIS_SET_B && !ch123_q[`AIS_C123_NB_HI]
		|=> route_q[1].neg_vref && route_q[2].neg_vref && route_q[3].neg_vref)
		else $error("ch1-3 set B negative not on reference");

	a_ch123_pos_hi: assert property (
		!twelve_bit_mode && set_q == AIS_SET_B && ch123_q[`AIS_C123_SB]
		|=> route_q[1].pos_pin == `AIS_POS_HI_BASE)
		else $error("ch1-3 set B positive high trio wrong");

	a_ch0_pos_limit: assert property (
		SECOND_CONV && !route_q[0].pos_vref |-> route_q[0].pos_pin <= 5'h0F)
		else $error("second converter ch0 positive above pin 15");

	a_absent_digital: assert property (
		(pin_digital_q & ~PIN_MASK) == 32'h0000_0000)
		else $error("absent pin left in digital mode");

	a_peer_analog: assert property (
		HAS_PEER && !converter_module_disable
		|=> (pin_digital_q[15:0] & ~$past(peer_pin_digital_mode_bit_low)) == 16'h0000)
		else $error("shared pin digital though peer wants analog");

	a_upper_zero: assert property (
		prdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");

	a_idle_no_err: assert property (
		!access |-> !pslverr)
		else $error("slave error outside access phase");
endmodule : ais_input_select
`default_nettype wire

// *** ais_conv_model.sv ***
`default_nettype none
module ais_conv_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// request from bench
	input  wire logic       go,
	input  wire logic [3:0] dly,
	// end of one sample
	output var  logic       sample_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] cnt_q;
	// one pulse per request, after dly idle cycles
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q       <= 5'h00;
			sample_done <= 1'b0;
		end else begin
			sample_done <= (cnt_q == 5'h01);
			if (go)
				cnt_q <= {1'b0, dly} + 5'h01;
			else if (cnt_q != 5'h00)
				cnt_q <= cnt_q - 5'h01;
		end
	end
endmodule : ais_conv_model
`default_nettype wire

// *** adc_input_select_port_config_test.sv ***
`include "ais_defs.svh"
`default_nettype none
module adc_input_select_port_config_test import ais_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [31:0] rexp;
		logic        eexp;
		logic [31:0] rexp2;
		logic        eexp2;
	} ais_row_type;
	logic            clk = 1'b0;
	logic            rst_b = 1'b0;
	ais_apb_req_type req = '0;
	logic [31:0]     prdata, pin_digital_q, rd;
	logic            pready, pslverr, err, sample_done, go = 1'b0;
	logic            twelve = 1'b0, dis = 1'b0, scan_en = 1'b0, alt = 1'b0;
	logic [3:0]      dly = 4'h0;
	logic [31:0]     prdata2, dig2, rd2;
	logic            pslverr2, err2;
	logic [15:0]     peer = 16'hFFDF;
	ais_route_type   route2 [4];
	ais_route_type   route_q [4];
	ais_set_type     set_q;
	logic [4:0]      scan_idx_q, p;
	logic [2:0]      c;
	logic [4:0]      sq [4] = '{5'h02, 5'h05, 5'h1F, 5'h02};
	int              miscompares = 0, n_compared = 0, cyc = 0;
	ais_row_type     rows [7] = '{
		'{`AIS_OFF_CH123, 32'hFFFF_FFFF, {16'h0000, `AIS_WM_CH123}, 1'b0,
			{16'h0000, `AIS_WM_CH123}, 1'b0},
		'{`AIS_OFF_CH0, 32'hFFFF_FFFF, {16'h0000, `AIS_WM_CH0}, 1'b0,
			{16'h0000, `AIS_WM_CH0_LOW}, 1'b0},
		'{`AIS_OFF_SCANH, 32'hFFFF_FFFF, 32'h0000_FFFF, 1'b0, 32'h0000_FFFF, 1'b0},
		'{`AIS_OFF_SCANL, 32'h0000_5A5A, 32'h0000_5A5A, 1'b0, 32'h0000_5A5A, 1'b0},
		'{`AIS_OFF_PCFGH, 32'h0000_FF00, 32'h0000_FF00, 1'b0, 32'h0000_0000, 1'b1},
		'{`AIS_OFF_PCFGL, 32'h0000_00F0, 32'h0000_00F0, 1'b0, 32'h0000_00F0, 1'b0},
		'{12'h018, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 32'h0000_0000, 1'b1}};

	ais_input_select dut (.clk(clk), .rst_b(rst_b), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .twelve_bit_mode(twelve),
		.converter_module_disable(dis), .scan_enable(scan_en),
		.alternate_sample_mode(alt), .sample_done(sample_done), .peer_pin_digital_mode_bit_low(16'hFFFF),
		.route_q(route_q), .set_q(set_q), .scan_idx_q(scan_idx_q),
		.pin_digital_q(pin_digital_q));
	ais_conv_model model (.clk(clk), .rst_b(rst_b), .go(go), .dly(dly),
		.sample_done(sample_done));
	// second converter, 16 pins, shared low config
	ais_input_select #(.NUM_PINS(16), .SECOND_CONV(1'b1), .HAS_PEER(1'b1)) dut2 (
		.clk(clk), .rst_b(rst_b), .apb_req(req), .prdata(prdata2), .pready(),
		.pslverr(pslverr2), .twelve_bit_mode(twelve), .converter_module_disable(dis),
		.scan_enable(scan_en), .alternate_sample_mode(alt), .sample_done(sample_done),
		.peer_pin_digital_mode_bit_low(peer), .route_q(route2), .set_q(), .scan_idx_q(),
		.pin_digital_q(dig2));

	always #2 clk = ~clk;

	task automatic stop_test;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		rd2 = prdata2;
		err2 = pslverr2;
		req <= '0;
	endtask : apb

	task automatic chk_rt(input int ch, input logic [4:0] pp, input logic np,
		input logic [4:0] nn);
		ais_route_type ex;
		ex = '{pos_pin: pp, pos_vref: 1'b0, neg_pin: np ? nn : 5'h00, neg_vref: !np};
		chk($sformatf("route%0d", ch), 32'(ex), 32'(route_q[ch]));
	endtask : chk_rt

	task automatic chk_c123(input logic [2:0] x);
		for (int ch = 1; ch < 4; ch++)
			chk_rt(ch, 5'((x[0] ? 3 : 0) + ch - 1), x[2], 5'((x[1] ? 9 : 6) + ch - 1));
	endtask : chk_c123

	task automatic samp(input logic [3:0] d);
		@(posedge clk);
		go <= 1'b1;
		dly <= d;
		@(posedge clk);
		go <= 1'b0;
		do @(posedge clk); while (sample_done !== 1'b1);
		@(posedge clk);
		#1;
	endtask : samp

	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk("set", 32'(AIS_SET_A), 32'(set_q));
		chk("digital", 32'h0000_0000, pin_digital_q);
		foreach (rows[i]) begin
			apb(1'b0, rows[i].addr, 32'h0000_0000);
			chk("reset_rd", 32'h0000_0000, rd);
			chk("reset_rd2", 32'h0000_0000, rd2);
			apb(1'b1, rows[i].addr, rows[i].wdata);
			chk("wr_err", 32'(rows[i].eexp), 32'(err));
			chk("wr_err2", 32'(rows[i].eexp2), 32'(err2));
			apb(1'b0, rows[i].addr, 32'h0000_0000);
			chk("rd", rows[i].rexp, rd);
			chk("rd2", rows[i].rexp2, rd2);
		end
		@(posedge clk);
		#1;
		chk("digital", 32'hFF00_00F0, pin_digital_q);
		chk("digital2", 32'h0000_00D0, dig2);
		@(posedge clk);
		dis <= 1'b1;
		twelve <= 1'b1;
		@(posedge clk);
		#1;
		chk("digital", 32'hFFFF_FFFF, pin_digital_q);
		chk("digital2", 32'h0000_FFFF, dig2);
		apb(1'b0, `AIS_OFF_CH123, 32'h0000_0000);
		chk("c123_12b", 32'h0000_0000, rd);
		apb(1'b1, `AIS_OFF_CH123, 32'h0000_0000);
		@(posedge clk);
		dis <= 1'b0;
		twelve <= 1'b0;
		alt <= 1'b1;
		apb(1'b0, `AIS_OFF_CH123, 32'h0000_0000);
		chk("c123", {16'h0000, `AIS_WM_CH123}, rd);
		for (int k = 0; k < 8; k++) begin
			c = 3'(k);
			p = 5'(k * 9);
			apb(1'b1, `AIS_OFF_CH123, {16'h0000, 5'h00, c, 5'h00, ~c});
			apb(1'b1, `AIS_OFF_CH0, {16'h0000, c[0], 2'b00, ~p, !c[0], 2'b00, p});
			@(posedge clk);
			#1;
			chk_rt(0, p, !c[0], 5'h01);
			chk_c123(~c);
			chk("pos2", {28'h000_0000, p[3:0]}, 32'(route2[0].pos_pin));
			samp(4'(k));
			chk("set", 32'(AIS_SET_B), 32'(set_q));
			chk_rt(0, ~p, c[0], 5'h01);
			chk_c123(c);
			chk("pos2", {28'h000_0000, ~p[3:0]}, 32'(route2[0].pos_pin));
			samp(4'h0);
			chk("set", 32'(AIS_SET_A), 32'(set_q));
		end
		@(posedge clk);
		alt <= 1'b0;
		scan_en <= 1'b1;
		apb(1'b1, `AIS_OFF_SCANL, 32'h0000_0024);
		apb(1'b1, `AIS_OFF_SCANH, 32'h0000_8000);
		foreach (sq[i]) begin
			samp(4'h1);
			chk("scan_idx", 32'(sq[i]), 32'(scan_idx_q));
			chk("scan_pin", 32'(sq[i]), 32'(route_q[0].pos_pin));
			chk("scan_ref2", 32'(sq[i][4]), 32'(route2[0].pos_vref));
		end
		@(posedge clk);
		scan_en <= 1'b0;
		samp(4'h0);
		chk("scan_idx", 32'h0000_0002, 32'(scan_idx_q));
		chk("ch0_pos", 32'h0000_001F, 32'(route_q[0].pos_pin));
		stop_test();
	end
endmodule : adc_input_select_port_config_test
`default_nettype wire
